// ---- verilog/rcf_pkg.sv ----
/*
 * rcf_pkg: register map, field layout, reset values, bandwidth units and
 * mode encodings for the receive channel filter configuration block.
 * assumes: a single 32-bit AHB-Lite slave; each register is one word and
 * its byte address is four times its index.
 */
package rcf_pkg;

	// register indices
	localparam logic [7:0] RCF_IDX_IFBW    = 8'h1C;
	localparam logic [7:0] RCF_IDX_MODE1   = 8'h70;
	localparam logic [7:0] RCF_IDX_MODE2   = 8'h71;
	localparam logic [7:0] RCF_IDX_RATE    = 8'h60;
	localparam logic [7:0] RCF_IDX_STATUS  = 8'h64;

	// register byte addresses, four times the index
	localparam logic [9:0] RCF_ADDR_IFBW   = {RCF_IDX_IFBW, 2'h0};
	localparam logic [9:0] RCF_ADDR_MODE1  = {RCF_IDX_MODE1, 2'h0};
	localparam logic [9:0] RCF_ADDR_MODE2  = {RCF_IDX_MODE2, 2'h0};
	localparam logic [9:0] RCF_ADDR_RATE   = {RCF_IDX_RATE, 2'h0};
	localparam logic [9:0] RCF_ADDR_STATUS = {RCF_IDX_STATUS, 2'h0};

	// filter bandwidth fields
	localparam int RCF_SKIP_BIT = 7;
	localparam int RCF_DEC_HI   = 6;
	localparam int RCF_DEC_LO   = 4;
	localparam int RCF_SET_HI   = 3;
	localparam int RCF_SET_LO   = 0;

	// mode control fields
	localparam int RCF_MANCH_BIT = 1;
	localparam int RCF_MODT_HI   = 1;
	localparam int RCF_MODT_LO   = 0;

	// reset values
	localparam logic [7:0]  RCF_IFBW_RST  = 8'h01;
	localparam logic [7:0]  RCF_MODE1_RST = 8'h00;
	localparam logic [7:0]  RCF_MODE2_RST = 8'h00;
	localparam logic [15:0] RCF_RATE_RST  = 16'h0000;
	localparam logic [2:0]  RCF_ADV_RST   = 3'h5;

	// modulation type codes
	localparam logic [1:0] RCF_MT_NONE = 2'h0;
	localparam logic [1:0] RCF_MT_OOK  = 2'h1;
	localparam logic [1:0] RCF_MT_FSK  = 2'h2;
	localparam logic [1:0] RCF_MT_GFSK = 2'h3;

	// effective rate thresholds, kbps, for decimation advice
	localparam logic [16:0] RCF_TH1  = 17'h00001;
	localparam logic [16:0] RCF_TH2  = 17'h00002;
	localparam logic [16:0] RCF_TH3  = 17'h00003;
	localparam logic [16:0] RCF_TH8  = 17'h00008;
	localparam logic [16:0] RCF_TH40 = 17'h00028;
	localparam logic [16:0] RCF_TH65 = 17'h00041;

	// modulation index window, in units of one half
	localparam logic [6:0] RCF_HIDX_MIN = 7'h01;
	localparam logic [6:0] RCF_HIDX_MAX = 7'h40;

	// bandwidths in units of 0.1 kHz
	localparam logic [12:0] RCF_BW_NONE = 13'h0000;

	typedef enum logic [1:0] {
		RCF_DEM_IDLE,
		RCF_DEM_OOK,
		RCF_DEM_FSK
	} rcf_dem_e;

endpackage : rcf_pkg

// ---- verilog/rcf_filter_config.sv ----
/*
 * rcf_filter_config: channel filter and demodulator mode configuration,
 * AHB-Lite register slave, bandwidth decode and decimation advice.
 * assumes: single word transfers, one clock, inputs synchronous to clk_sys;
 * register byte address is four times the register index;
 * only address bits 9 to 0 are decoded, upper bits ignored;
 * sample_stb is a one-cycle pulse, one per received sample;
 * deviation_khz is held steady by the demodulator between changes.
 */
// The AHB-Lite interface to the registers was chosen for this implementation.
// Functional notes
// - fsk/gfsk accepts modulation index 0.5 to 32 inclusive
// - manchester flag doubles effective symbol rate over payload rate
// - afc absorbs error up to half modulation bandwidth, filter unchanged
// - bandwidth register: bit7 skip, bits6-4 exponent, bits3-0 set index
// - skip 0 gives 2.6 to 137.9 khz, skip 1 up to 620.7
// - modulation type field at 71h selects ook demodulation
// - ook rate, manchester, filter, oversampling set independently
// - manchester enable bit lives in register 70h
// - ook bandwidth table through 1ch, 75.2 to 620.7 khz
// - bandwidth register at 1ch drives filter response from the next sample_stb
`timescale 1ns/1ps
`default_nettype none

module rcf_filter_config
	import rcf_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// demodulator sample side
	input  wire logic        sample_stb,
	input  wire logic [7:0]  deviation_khz,
	// filter and demodulator controls
	output logic             div_three_skip,
	output logic      [2:0]  dec_exp,
	output logic      [3:0]  filter_set,
	output logic      [12:0] chan_bw,
	output logic             bw_valid,
	output logic             ook_mode,
	output logic             fsk_mode,
	output logic             manch_en,
	output logic      [16:0] eff_rate,
	output logic      [2:0]  dec_advice,
	output logic             index_ok
);

	// bandwidth lookup, 0.1 khz units, zero where not offered
	function automatic logic [12:0] bw_lookup(
		input logic       skip,
		input logic [2:0] dex,
		input logic [3:0] fs
	);
		logic [12:0] b;
		b = RCF_BW_NONE;
		if (skip) begin
			if (dex == 3'h0) begin
				case (fs)
					4'h1: b = 13'd2251;
					4'h2: b = 13'd2488;
					4'h3: b = 13'd2693;
					4'h4: b = 13'd2849;
					4'h8: b = 13'd3355;
					4'h9: b = 13'd3618;
					4'hA: b = 13'd4202;
					4'hB: b = 13'd4684;
					4'hC: b = 13'd5188;
					4'hD: b = 13'd5770;
					4'hE: b = 13'd6207;
					4'hF: b = 13'd1915;
					default: b = RCF_BW_NONE;
				endcase
			end else if (dex == 3'h1) begin
				case (fs)
					4'h4: b = 13'd1428;
					4'h5: b = 13'd1678;
					4'h9: b = 13'd1811;
					default: b = RCF_BW_NONE;
				endcase
			end
		end else begin
			case ({dex, fs})
				7'h51: b = 13'd26;
				7'h52: b = 13'd28;
				7'h53: b = 13'd31;
				7'h54: b = 13'd32;
				7'h55: b = 13'd37;
				7'h56: b = 13'd42;
				7'h57: b = 13'd45;
				7'h41: b = 13'd49;
				7'h42: b = 13'd54;
				7'h43: b = 13'd59;
				7'h44: b = 13'd61;
				7'h45: b = 13'd72;
				7'h46: b = 13'd82;
				7'h47: b = 13'd88;
				7'h31: b = 13'd95;
				7'h32: b = 13'd106;
				7'h33: b = 13'd115;
				7'h34: b = 13'd121;
				7'h35: b = 13'd142;
				7'h36: b = 13'd162;
				7'h37: b = 13'd175;
				7'h21: b = 13'd189;
				7'h22: b = 13'd210;
				7'h23: b = 13'd227;
				7'h24: b = 13'd240;
				7'h25: b = 13'd282;
				7'h26: b = 13'd322;
				7'h27: b = 13'd347;
				7'h11: b = 13'd377;
				7'h12: b = 13'd417;
				7'h13: b = 13'd452;
				7'h14: b = 13'd479;
				7'h15: b = 13'd562;
				7'h16: b = 13'd641;
				7'h17: b = 13'd692;
				7'h01: b = 13'd752;
				7'h02: b = 13'd832;
				7'h03: b = 13'd900;
				7'h04: b = 13'd953;
				7'h05: b = 13'd1121;
				7'h06: b = 13'd1279;
				7'h07: b = 13'd1379;
				default: b = RCF_BW_NONE;
			endcase
		end
		return b;
	endfunction : bw_lookup

	// register state
	logic [7:0]  ifbw_ff;
	logic [7:0]  mode1_ff;
	logic [7:0]  mode2_ff;
	logic [15:0] rate_ff;
	logic [7:0]  act_ff;
	logic        pend_ff;
	// data phase capture
	logic        wr_ff;
	logic        rd_ff;
	logic [7:0]  addr_ff;
	logic [31:0] rdata_ff;
	// derived outputs
	logic [12:0] bw_ff;
	logic        bwv_ff;
	logic [16:0] eff_ff;
	logic [2:0]  adv_ff;
	logic        hok_ff;
	rcf_dem_e    dem_ff;

	// address phase decode, data phase register hits and write strobes
	wire         acc_take  = hsel & hready & htrans[1];
	wire         word_ok   = (hsize == 3'h2) & (haddr[1:0] == 2'h0);
	wire         nxt_wr    = acc_take & hwrite & word_ok;
	wire         nxt_rd    = acc_take & ~hwrite;
	wire  [7:0]  a_lo      = haddr[9:2];
	wire         hit_ifbw  = addr_ff == RCF_IDX_IFBW;
	wire         hit_mode1 = addr_ff == RCF_IDX_MODE1;
	wire         hit_mode2 = addr_ff == RCF_IDX_MODE2;
	wire         hit_rate  = addr_ff == RCF_IDX_RATE;
	wire         hit_stat  = addr_ff == RCF_IDX_STATUS;
	wire         wr_ifbw   = wr_ff & hit_ifbw;
	wire         wr_mode1  = wr_ff & hit_mode1;
	wire         wr_mode2  = wr_ff & hit_mode2;
	wire         wr_rate   = wr_ff & hit_rate;

	// status word: bit0 fsk, bit1 ook, bit4 pending, bits7-5 advice,
	// bits9-8 demodulator, bit10 index ok, bit11 bandwidth valid
	wire  [31:0] stat_word = {
		20'h00000,
		bwv_ff,
		hok_ff,
		dem_ff,
		adv_ff,
		pend_ff,
		2'h0,
		ook_mode,
		fsk_mode
	};

	// readback words, upper bits read zero
	wire  [31:0] rd_ifbw   = {24'h000000, ifbw_ff};
	wire  [31:0] rd_mode1  = {24'h000000, mode1_ff};
	wire  [31:0] rd_mode2  = {24'h000000, mode2_ff};
	wire  [31:0] rd_rate   = {16'h0000, rate_ff};

	// read mux, no side effects on any read
	wire  [31:0] rd_mux =
		hit_ifbw  ? rd_ifbw :
		hit_mode1 ? rd_mode1 :
		hit_mode2 ? rd_mode2 :
		hit_rate  ? rd_rate :
		hit_stat  ? stat_word :
		32'h00000000;

	// mode decode
	wire  [1:0]  modt     = mode2_ff[RCF_MODT_HI:RCF_MODT_LO];
	wire         is_ook   = modt == RCF_MT_OOK;
	wire         is_fsk   = (modt == RCF_MT_FSK) | (modt == RCF_MT_GFSK);
	wire         manch    = mode1_ff[RCF_MANCH_BIT];
	wire  [16:0] nxt_eff  = manch ? {rate_ff, 1'b0} : {1'b0, rate_ff};

	// decimation advice from effective rate
	wire  [2:0]  nxt_adv  =
		(nxt_eff <= RCF_TH1)  ? 3'h5 :
		(nxt_eff <= RCF_TH2)  ? 3'h4 :
		(nxt_eff <= RCF_TH3)  ? 3'h3 :
		(nxt_eff <= RCF_TH8)  ? 3'h2 :
		(nxt_eff <= RCF_TH40) ? 3'h1 : 3'h0;

	// index h = 2 fd / eff, check 0.5 <= h <= 32 by cross products
	wire  [18:0] fd4      = {9'h000, deviation_khz, 2'h0};
	wire  [23:0] eff_lo   = {7'h00, nxt_eff} * {17'h00000, RCF_HIDX_MIN};
	wire  [23:0] eff_hi   = {7'h00, nxt_eff} * {17'h00000, RCF_HIDX_MAX};
	wire  [23:0] fd4_w    = {5'h00, fd4};
	wire         h_lo_ok  = fd4_w >= eff_lo;
	wire         h_hi_ok  = fd4_w <= eff_hi;
	wire         nxt_hok  = is_fsk & (nxt_eff != 17'h00000)
		& h_lo_ok & h_hi_ok;

	// active filter fields, new value latched at next sample
	wire  [7:0]  nxt_act  = (pend_ff & sample_stb) ? ifbw_ff : act_ff;
	wire  [12:0] nxt_bw   = bw_lookup(act_ff[RCF_SKIP_BIT],
		act_ff[RCF_DEC_HI:RCF_DEC_LO], act_ff[RCF_SET_HI:RCF_SET_LO]);
	wire         nxt_pend = wr_ifbw | (pend_ff & ~sample_stb);

	// demodulator state
	rcf_dem_e    nxt_dem;
	always_comb begin
		case ({is_ook, is_fsk})
			2'h2:    nxt_dem = RCF_DEM_OOK;
			2'h1:    nxt_dem = RCF_DEM_FSK;
			default: nxt_dem = RCF_DEM_IDLE;
		endcase
	end

	// bus phase capture
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ff   <= 1'b0;
			rd_ff   <= 1'b0;
			addr_ff <= 8'h00;
		end else begin
			wr_ff   <= nxt_wr;
			rd_ff   <= nxt_rd;
			addr_ff <= a_lo;
		end
	end

	// software registers, each field independent
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ifbw_ff  <= RCF_IFBW_RST;
			mode1_ff <= RCF_MODE1_RST;
			mode2_ff <= RCF_MODE2_RST;
			rate_ff  <= RCF_RATE_RST;
		end else begin
			if (wr_ifbw) ifbw_ff <= hwdata[7:0];
			if (wr_mode1) mode1_ff <= hwdata[7:0];
			if (wr_mode2) mode2_ff <= hwdata[7:0];
			if (wr_rate) rate_ff <= hwdata[15:0];
		end
	end

	// active filter fields and pending flag
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			act_ff  <= RCF_IFBW_RST;
			pend_ff <= 1'b0;
		end else begin
			act_ff  <= nxt_act;
			pend_ff <= nxt_pend;
		end
	end

	// bandwidth of the active setting
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bw_ff  <= RCF_BW_NONE;
			bwv_ff <= 1'b0;
		end else begin
			bw_ff  <= nxt_bw;
			bwv_ff <= nxt_bw != RCF_BW_NONE;
		end
	end

	// rate, advice, index check and demodulator mode
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			eff_ff <= 17'h00000;
			adv_ff <= RCF_ADV_RST;
			hok_ff <= 1'b0;
			dem_ff <= RCF_DEM_IDLE;
		end else begin
			eff_ff <= nxt_eff;
			adv_ff <= nxt_adv;
			hok_ff <= nxt_hok;
			dem_ff <= nxt_dem;
		end
	end

	// read data held after the data phase
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 32'h00000000;
		end else begin
			rdata_ff <= rd_ff ? rd_mux : rdata_ff;
		end
	end

	// afc corrects small offsets; filter fields are never widened here
	assign div_three_skip = act_ff[RCF_SKIP_BIT];
	assign dec_exp        = act_ff[RCF_DEC_HI:RCF_DEC_LO];
	assign filter_set     = act_ff[RCF_SET_HI:RCF_SET_LO];
	assign chan_bw        = bw_ff;
	assign bw_valid       = bwv_ff;
	assign ook_mode       = dem_ff == RCF_DEM_OOK;
	assign fsk_mode       = dem_ff == RCF_DEM_FSK;
	assign manch_en       = manch;
	assign eff_rate       = eff_ff;
	assign dec_advice     = adv_ff;
	assign index_ok       = hok_ff;
	assign hrdata         = rd_ff ? rd_mux : rdata_ff;
	assign hreadyout      = 1'b1;
	assign hresp          = 1'b0;

endmodule : rcf_filter_config

`default_nettype wire

// ---- test/rcf_filter_config_assertions.sv ----
/*
 * checker for rcf_filter_config: bus, filter and mode outputs.
 * assumes: bound to the top module, one clock, async low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module rcf_filter_config_chk (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        sample_stb,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        div_three_skip,
	input wire logic [2:0]  dec_exp,
	input wire logic [3:0]  filter_set,
	input wire logic [12:0] chan_bw,
	input wire logic        bw_valid,
	input wire logic        ook_mode,
	input wire logic        fsk_mode,
	input wire logic        manch_en,
	input wire logic [16:0] eff_rate,
	input wire logic [2:0]  dec_advice,
	input wire logic        index_ok
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire [7:0] fld = {div_three_skip, dec_exp, filter_set};
	sequence s_rate_zero;
		eff_rate == 17'h00000 ##1 eff_rate == 17'h00000;
	endsequence
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus not ready or error");
	field_on_stb_a: assert property (!$stable(fld) |-> $past(sample_stb))
		else $error("filter fields moved without a sample");
	bw_valid_match_a: assert property (bw_valid == (chan_bw != 13'h0000))
		else $error("bw_valid disagrees with chan_bw");
	bw_low_a: assert property (fld == 8'h51 |=> chan_bw == 13'h001A)
		else $error("lowest bandwidth wrong");
	bw_top_a: assert property (fld == 8'h8E |=> chan_bw == 13'h183F)
		else $error("highest bandwidth wrong");
	mode_excl_a: assert property (!(ook_mode && fsk_mode))
		else $error("ook and fsk both set");
	manch_double_a: assert property ($stable(manch_en) && manch_en |-> !eff_rate[0])
		else $error("manchester rate not doubled");
	slow_advice_a: assert property (s_rate_zero |-> dec_advice == 3'h5)
		else $error("advice for zero rate wrong");
	index_mode_a: assert property (index_ok |-> fsk_mode)
		else $error("index ok outside fsk");
endmodule : rcf_filter_config_chk
`default_nettype wire

// ---- test/tb.sv ----
/*
 * tb: self-checking bench for rcf_filter_config over ahb-lite.
 * assumes: zero wait state slave, samples strobed by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rcf_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        sample_stb = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] q;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [7:0]  deviation_khz = 8'h00;
	wire [31:0]  hrdata;
	wire [12:0]  chan_bw;
	wire [16:0]  eff_rate;
	wire [2:0]   dec_exp, dec_advice;
	wire [3:0]   filter_set;
	wire         hreadyout, hresp, div_three_skip, bw_valid;
	wire         ook_mode, fsk_mode, manch_en, index_ok;
	int          n_fail = 0;
	int          n_checks = 0;
	always #5 clk_sys = ~clk_sys;
	rcf_filter_config uut (.clk_sys, .rst_n, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
		.hresp, .sample_stb, .deviation_khz, .div_three_skip, .dec_exp,
		.filter_set, .chan_bw, .bw_valid, .ook_mode, .fsk_mode, .manch_en,
		.eff_rate, .dec_advice, .index_ok);
	task automatic chk(input string n, input logic [31:0] e, s);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [9:0] a,
		input logic [31:0] d, input logic [2:0] sz);
		@(posedge clk_sys);
		hsel <= 1'b1; htrans <= 2'h2; hwrite <= w;
		haddr <= {22'h0, a}; hsize <= sz;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic stb();
		@(posedge clk_sys); sample_stb <= 1'b1;
		@(posedge clk_sys); sample_stb <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask : stb
	task automatic t_bw();
		logic [7:0] v[6] = '{8'h51, 8'h01, 8'h8F, 8'h8E, 8'h94, 8'h00};
		logic [12:0] e[6] = '{13'h001A, 13'h02F0, 13'h077B, 13'h183F,
			13'h0594, 13'h0000};
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, RCF_ADDR_IFBW, {24'h0, v[i]}, 3'h2);
			bus(1'b0, RCF_ADDR_IFBW, 32'h0, 3'h2);
			chk("ifbw readback", {24'h0, v[i]}, q);
			if (i > 0) chk("held", {28'h0, v[i-1][3:0]}, {28'h0, filter_set});
			stb();
			chk("fields", {24'h0, v[i]}, {24'h0, div_three_skip, dec_exp, filter_set});
			chk("chan_bw", {19'h0, e[i]}, {19'h0, chan_bw});
			chk("bw_valid", {31'h0, e[i] != 13'h0}, {31'h0, bw_valid});
		end
		$display("bandwidth test done");
	endtask : t_bw
	task automatic t_mode();
		logic [15:0] r[7] = '{16'h1, 16'h2, 16'h3, 16'h8, 16'h28, 16'h41, 16'h14};
		logic [2:0] a[7] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h1};
		for (int t = 0; t < 4; t++) begin
			bus(1'b1, RCF_ADDR_MODE2, t, 3'h2);
			repeat (3) @(posedge clk_sys);
			chk("ook", {31'h0, t == 1}, {31'h0, ook_mode});
			chk("fsk", {31'h0, t > 1}, {31'h0, fsk_mode});
		end
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, RCF_ADDR_MODE1, (i == 6) ? 32'h2 : 32'h0, 3'h2);
			bus(1'b1, RCF_ADDR_RATE, {16'h0, r[i]}, 3'h2);
			repeat (4) @(posedge clk_sys);
			chk("eff_rate", (i == 6) ? 32'h28 : {16'h0, r[i]}, {15'h0, eff_rate});
			chk("advice", {29'h0, a[i]}, {29'h0, dec_advice});
			chk("manch", {31'h0, i == 6}, {31'h0, manch_en});
		end
		$display("mode test done");
	endtask : t_mode
	task automatic t_index();
		logic [7:0] d[4] = '{8'h05, 8'h64, 8'hC8, 8'h02};
		bus(1'b1, RCF_ADDR_MODE1, 32'h0, 3'h2);
		bus(1'b1, RCF_ADDR_MODE2, {30'h0, RCF_MT_FSK}, 3'h2);
		bus(1'b1, RCF_ADDR_RATE, 32'hA, 3'h2);
		// 10 kbps, 5 khz: bw_mod 15 khz, next larger 16.2 khz
		bus(1'b1, RCF_ADDR_IFBW, 32'h36, 3'h2);
		stb();
		chk("fsk filter", 32'hA2, {19'h0, chan_bw});
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys); deviation_khz <= d[i];
			repeat (4) @(posedge clk_sys);
			chk("index_ok", {31'h0, i < 2}, {31'h0, index_ok});
		end
		$display("index test done");
	endtask : t_index
	task automatic t_refuse();
		bus(1'b1, 10'h044, 32'h5A, 3'h2);
		bus(1'b0, 10'h044, 32'h0, 3'h2);
		chk("unmapped", 32'h0, q);
		bus(1'b1, RCF_ADDR_IFBW, 32'h33, 3'h0);
		bus(1'b0, RCF_ADDR_IFBW, 32'h0, 3'h2);
		chk("bad size", 32'h36, q);
		chk("hresp", 32'h0, {31'h0, hresp});
		$display("refusal test done");
	endtask : t_refuse
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_bw();
		t_mode();
		t_index();
		t_refuse();
		report_and_stop();
	end
	initial begin
		#100000;
		n_fail++;
		report_and_stop();
	end
endmodule : tb
bind rcf_filter_config rcf_filter_config_chk chk (.clk_sys, .rst_n,
	.sample_stb, .hreadyout, .hresp, .div_three_skip, .dec_exp,
	.filter_set, .chan_bw, .bw_valid, .ook_mode, .fsk_mode, .manch_en,
	.eff_rate, .dec_advice, .index_ok);
`default_nettype wire
